// ---- rtl/fdm_monitor.sv ----
// Purpose: Per-channel over-range detection with thresholds, dwell release,
//          software force and signal-monitor sync to SYSREF edges.
// Assumes: Magnitudes arrive on clk; sysref_in is an asynchronous pin.
// Notes:   Writes go to every channel set in reg_chan_mask; reads come from
//          the lowest channel set in the mask.
`timescale 1ns/1ps
module fdm_monitor (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // Register access port
    input  wire logic [fdm_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [fdm_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [fdm_pkg::NUM_CH-1:0]    reg_chan_mask,
    output logic      [fdm_pkg::DATA_W-1:0]    reg_rdata,
    output logic                               reg_rvalid,
    // Converter magnitudes
    input  wire logic [fdm_pkg::MAG_W-1:0]     mag_a,
    input  wire logic [fdm_pkg::MAG_W-1:0]     mag_b,
    // SYSREF pin and monitor sync pulses
    input  wire logic                          sysref_in,
    output logic      [fdm_pkg::NUM_CH-1:0]    monitor_sync,
    // Over-range pins
    output logic                               overrange_out_a,
    output logic                               overrange_out_b
);
    import fdm_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [DATA_W-1:0]  pin_ctrl_r  [NUM_CH];
    logic [DATA_W-1:0]  pin_ctrl_nxt[NUM_CH];
    logic [MAG_W-1:0]   upper_r     [NUM_CH];
    logic [MAG_W-1:0]   upper_nxt   [NUM_CH];
    logic [MAG_W-1:0]   lower_r     [NUM_CH];
    logic [MAG_W-1:0]   lower_nxt   [NUM_CH];
    logic [DWELL_W-1:0] dwell_r     [NUM_CH];
    logic [DWELL_W-1:0] dwell_nxt   [NUM_CH];
    logic [DATA_W-1:0]  sync_ctrl_r [NUM_CH];
    logic [DATA_W-1:0]  sync_ctrl_nxt[NUM_CH];
    logic [DWELL_W-1:0] cnt_r       [NUM_CH];
    logic [DWELL_W-1:0] cnt_nxt     [NUM_CH];
    logic [NUM_CH-1:0]  det_r;
    logic [NUM_CH-1:0]  det_nxt;
    logic [NUM_CH-1:0]  pin_r;
    logic [NUM_CH-1:0]  pin_nxt;
    logic [NUM_CH-1:0]  msync_r;
    logic [NUM_CH-1:0]  msync_nxt;
    logic [DATA_W-1:0]  rdata_r;
    logic [DATA_W-1:0]  rdata_nxt;
    logic               rvalid_r;
    logic               rvalid_nxt;
    logic               sysref_meta_r;
    logic               sysref_sync_r;
    logic               sysref_prev_r;
    logic               sysref_edge;
    logic [MAG_W-1:0]   mag [NUM_CH];
    logic [NUM_CH-1:0]  rd_sel;

    assign mag[0] = mag_a;
    assign mag[1] = mag_b;
    // Rising edge seen only after both synchroniser stages
    assign sysref_edge = sysref_sync_r & ~sysref_prev_r;

    // ----------------------------------------------------------------
    // SYSREF synchroniser
    // ----------------------------------------------------------------
    // Pin is asynchronous to clk, so two stages before any logic reads it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sysref_meta_r <= 1'b0;
            sysref_sync_r <= 1'b0;
            sysref_prev_r <= 1'b0;
        end else begin
            sysref_meta_r <= sysref_in;
            sysref_sync_r <= sysref_meta_r;
            sysref_prev_r <= sysref_sync_r;
        end
    end

    // ----------------------------------------------------------------
    // Control registers: next-state logic
    // ----------------------------------------------------------------
    // Software-only fields; a write reaches every channel set in the mask
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            pin_ctrl_nxt[c] = pin_ctrl_r[c];
            upper_nxt[c]    = upper_r[c];
            lower_nxt[c]    = lower_r[c];
            dwell_nxt[c]    = dwell_r[c];
            if (reg_wr && reg_chan_mask[c]) begin
                unique case (reg_addr)
                    ADDR_PIN_CTRL: begin
                        pin_ctrl_nxt[c] = reg_wdata & PIN_CTRL_MASK;
                    end
                    ADDR_UPPER_LO: begin
                        upper_nxt[c][7:0] = reg_wdata;
                    end
                    ADDR_UPPER_HI: begin
                        upper_nxt[c][MAG_W-1:8] = reg_wdata[THR_HI_W-1:0];
                    end
                    ADDR_LOWER_LO: begin
                        lower_nxt[c][7:0] = reg_wdata;
                    end
                    ADDR_LOWER_HI: begin
                        lower_nxt[c][MAG_W-1:8] = reg_wdata[THR_HI_W-1:0];
                    end
                    ADDR_DWELL_LO: begin
                        dwell_nxt[c][7:0] = reg_wdata;
                    end
                    ADDR_DWELL_HI: begin
                        dwell_nxt[c][15:8] = reg_wdata;
                    end
                    // Sync control lives with the sync logic; unmapped writes drop
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers: state
    // ----------------------------------------------------------------
    // Thresholds reset to zero, so any nonzero magnitude trips the detector
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < NUM_CH; c++) begin
                pin_ctrl_r[c] <= REG_RESET;
                upper_r[c]    <= '0;
                lower_r[c]    <= '0;
                dwell_r[c]    <= DWELL_RESET;
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                pin_ctrl_r[c] <= pin_ctrl_nxt[c];
                upper_r[c]    <= upper_nxt[c];
                lower_r[c]    <= lower_nxt[c];
                dwell_r[c]    <= dwell_nxt[c];
            end
        end
    end

    // ----------------------------------------------------------------
    // Threshold detector with dwell release: next-state logic
    // ----------------------------------------------------------------
    // The detector runs even while the pin is disabled, so enabling the
    // pin shows the current verdict at once rather than a stale one
    always_comb begin
        det_nxt = det_r;
        for (int c = 0; c < NUM_CH; c++) begin
            cnt_nxt[c] = cnt_r[c];
            if (mag[c] > upper_r[c]) begin
                det_nxt[c] = 1'b1;
                cnt_nxt[c] = dwell_r[c];
            end else if (mag[c] >= lower_r[c]) begin
                cnt_nxt[c] = dwell_r[c];
            end else if (cnt_r[c] <= 16'h0001) begin
                // A dwell of zero behaves like one: release on the first low sample
                det_nxt[c] = 1'b0;
                cnt_nxt[c] = 16'h0000;
            end else begin
                cnt_nxt[c] = cnt_r[c] - 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Threshold detector: state
    // ----------------------------------------------------------------
    // Counter idles at zero after reset, so the first low sample releases
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            det_r <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
                cnt_r[c] <= DWELL_RESET;
            end
        end else begin
            det_r <= det_nxt;
            for (int c = 0; c < NUM_CH; c++) begin
                cnt_r[c] <= cnt_nxt[c];
            end
        end
    end

    // ----------------------------------------------------------------
    // Over-range pins: next-state logic
    // ----------------------------------------------------------------
    // Force beats enable; a disabled, unforced pin sits low
    always_comb begin
        pin_nxt = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            if (pin_ctrl_r[c][PIN_FORCE_BIT]) begin
                pin_nxt[c] = pin_ctrl_r[c][PIN_FVAL_BIT];
            end else if (pin_ctrl_r[c][PIN_EN_BIT]) begin
                pin_nxt[c] = det_nxt[c];
            end else begin
                pin_nxt[c] = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Over-range pins: state
    // ----------------------------------------------------------------
    // Pins are registered so the host never sees a glitch from the compare
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_r <= '0;
        end else begin
            pin_r <= pin_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Monitor sync: next-state logic
    // ----------------------------------------------------------------
    // Next-edge mode disarms itself after one edge; a software write in the
    // same cycle comes last, so a re-arm is never lost to the auto-clear
    always_comb begin
        msync_nxt = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            sync_ctrl_nxt[c] = sync_ctrl_r[c];
            if (sysref_edge && sync_ctrl_r[c][SYNC_EN_BIT]) begin
                msync_nxt[c] = 1'b1;
                if (sync_ctrl_r[c][SYNC_MODE_BIT]) begin
                    sync_ctrl_nxt[c][SYNC_EN_BIT] = 1'b0;
                end
            end
            if (reg_wr && reg_chan_mask[c] && reg_addr == ADDR_SYNC_CTRL) begin
                sync_ctrl_nxt[c] = reg_wdata & SYNC_CTRL_MASK;
            end
        end
    end

    // ----------------------------------------------------------------
    // Monitor sync: state
    // ----------------------------------------------------------------
    // Sync pulse is one clock wide, registered like every other output
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msync_r <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
                sync_ctrl_r[c] <= REG_RESET;
            end
        end else begin
            msync_r <= msync_nxt;
            for (int c = 0; c < NUM_CH; c++) begin
                sync_ctrl_r[c] <= sync_ctrl_nxt[c];
            end
        end
    end

    // ----------------------------------------------------------------
    // Register read port: next-state logic
    // ----------------------------------------------------------------
    // Reads come from channel A when its mask bit is set, else channel B;
    // read data holds its last value between reads
    always_comb begin
        rd_sel     = reg_chan_mask[0] ? 2'b01 : 2'b10;
        rdata_nxt  = rdata_r;
        rvalid_nxt = reg_rd;
        for (int c = 0; c < NUM_CH; c++) begin
            if (reg_rd && rd_sel[c]) begin
                unique case (reg_addr)
                    ADDR_PIN_CTRL:  rdata_nxt = pin_ctrl_r[c];
                    ADDR_UPPER_LO:  rdata_nxt = upper_r[c][7:0];
                    ADDR_UPPER_HI:  rdata_nxt = {3'h0, upper_r[c][MAG_W-1:8]};
                    ADDR_LOWER_LO:  rdata_nxt = lower_r[c][7:0];
                    ADDR_LOWER_HI:  rdata_nxt = {3'h0, lower_r[c][MAG_W-1:8]};
                    ADDR_DWELL_LO:  rdata_nxt = dwell_r[c][7:0];
                    ADDR_DWELL_HI:  rdata_nxt = dwell_r[c][15:8];
                    ADDR_SYNC_CTRL: rdata_nxt = sync_ctrl_r[c];
                    default:        rdata_nxt = 8'h00;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Register read port: state
    // ----------------------------------------------------------------
    // Answer comes exactly one clock after the read strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from flops
    // ----------------------------------------------------------------
    assign overrange_out_a = pin_r[0];
    assign overrange_out_b = pin_r[1];
    assign monitor_sync    = msync_r;
    assign reg_rdata       = rdata_r;
    assign reg_rvalid      = rvalid_r;
endmodule : fdm_monitor

// ---- rtl/fdm_pkg.sv ----
// Purpose: Shared constants for the over-range (fast detect) threshold monitor.
// Assumes: Byte-wide local registers, with one copy per converter channel.
// Notes:   Printed register offsets are used as the register addresses.
package fdm_pkg;
    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int NUM_CH   = 2;
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 8;
    localparam int MAG_W    = 13;
    localparam int DWELL_W  = 16;
    localparam int THR_HI_W = 5;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_PIN_CTRL  = 12'h245;
    localparam logic [ADDR_W-1:0] ADDR_UPPER_LO  = 12'h247;
    localparam logic [ADDR_W-1:0] ADDR_UPPER_HI  = 12'h248;
    localparam logic [ADDR_W-1:0] ADDR_LOWER_LO  = 12'h249;
    localparam logic [ADDR_W-1:0] ADDR_LOWER_HI  = 12'h24A;
    localparam logic [ADDR_W-1:0] ADDR_DWELL_LO  = 12'h24B;
    localparam logic [ADDR_W-1:0] ADDR_DWELL_HI  = 12'h24C;
    localparam logic [ADDR_W-1:0] ADDR_SYNC_CTRL = 12'h26F;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PIN_EN_BIT     = 0;
    localparam int PIN_FVAL_BIT   = 2;
    localparam int PIN_FORCE_BIT  = 3;
    localparam int SYNC_EN_BIT    = 0;
    localparam int SYNC_MODE_BIT  = 1;

    // Writable bit masks; every other bit is reserved and reads zero
    localparam logic [DATA_W-1:0] PIN_CTRL_MASK  = 8'h0D;
    localparam logic [DATA_W-1:0] THR_HI_MASK    = 8'h1F;
    localparam logic [DATA_W-1:0] SYNC_CTRL_MASK = 8'h03;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [DWELL_W-1:0] DWELL_RESET = 16'h0000;
endpackage : fdm_pkg

// ---- test/fdm_host_model.sv ----
// Purpose: Host-side source of SYSREF pulses for the monitor.
// Assumes: Monitor period is its reset value of 128 cycles.
// Notes:   Line idles low between pulses, like a real SYSREF source.
`timescale 1ns/1ps
module fdm_host_model (
    // Clock and SYSREF line
    input  wire logic clk,
    output logic      sysref_in
);
    localparam int PERIOD = 128; // Multiple of the monitor period
    initial sysref_in = 1'b0;
    // High for 4 cycles so the synchroniser sees a clean edge
    task automatic send(input int n);
        repeat (n) begin
            @(negedge clk);
            sysref_in = 1'b1;
            repeat (4) @(negedge clk);
            sysref_in = 1'b0;
            repeat (PERIOD - 5) @(negedge clk);
        end
    endtask : send
endmodule : fdm_host_model

// ---- test/fdm_monitor_checker.sv ----
// Purpose: Port-level checks for the over-range monitor, channel A.
// Assumes: Channel A control is mirrored from register writes.
// Notes:   Sync bounds assume SYSREF high 4 cycles, low long after.
`timescale 1ns/1ps
module fdm_monitor_checker import fdm_pkg::*; (
    // Clock, reset, register port
    input wire logic                clk,
    input wire logic                rst,
    input wire logic [ADDR_W-1:0]   reg_addr,
    input wire logic [DATA_W-1:0]   reg_wdata,
    input wire logic                reg_wr,
    input wire logic [NUM_CH-1:0]   reg_chan_mask,
    input wire logic [DATA_W-1:0]   reg_rdata,
    input wire logic                reg_rvalid,
    // Sync and pins
    input wire logic                sysref_in,
    input wire logic [NUM_CH-1:0]   monitor_sync,
    input wire logic                overrange_out_a
);
    logic [DATA_W-1:0] ctl_r;
    logic [DATA_W-1:0] ctl_nxt;
    // Mirror of channel A pin control, reserved bits dropped
    always_comb begin
        ctl_nxt = ctl_r;
        if (reg_wr && reg_addr == ADDR_PIN_CTRL && reg_chan_mask[0]) begin
            ctl_nxt = reg_wdata & PIN_CTRL_MASK;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_r <= REG_RESET;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // A sync pulse lasts exactly one cycle
    sequence s_one_cycle;
        monitor_sync[0] ##1 !monitor_sync[0];
    endsequence
    property p_en_off;
        !ctl_r[PIN_FORCE_BIT] && !ctl_r[PIN_EN_BIT] |=> !overrange_out_a;
    endproperty
    property p_force_hi;
        ctl_r[PIN_FORCE_BIT] && ctl_r[PIN_FVAL_BIT] |=> overrange_out_a;
    endproperty
    property p_force_lo;
        ctl_r[PIN_FORCE_BIT] && !ctl_r[PIN_FVAL_BIT] |=> !overrange_out_a;
    endproperty
    property p_resv_ctl;
        reg_rvalid && $past(reg_addr) == ADDR_PIN_CTRL |-> (reg_rdata & ~PIN_CTRL_MASK) == 8'h00;
    endproperty
    property p_resv_upper;
        reg_rvalid && $past(reg_addr) == ADDR_UPPER_HI |-> reg_rdata[7:5] == 3'h0;
    endproperty
    property p_resv_lower;
        reg_rvalid && $past(reg_addr) == ADDR_LOWER_HI |-> reg_rdata[7:5] == 3'h0;
    endproperty
    property p_sync_pulse;
        $rose(monitor_sync[0]) |-> s_one_cycle;
    endproperty
    // A pulse needs a fresh SYSREF rise two to four cycles earlier
    property p_sync_cause;
        $rose(monitor_sync[0]) |-> $past(sysref_in, 2) && !$past(sysref_in, 5);
    endproperty
    a_en_off: assert property (p_en_off) else $error("pin high while disabled");
    a_force_hi: assert property (p_force_hi) else $error("forced high not seen");
    a_force_lo: assert property (p_force_lo) else $error("forced low not seen");
    a_resv_ctl: assert property (p_resv_ctl) else $error("control reserved bits set");
    a_resv_upper: assert property (p_resv_upper) else $error("upper high reserved bits set");
    a_resv_lower: assert property (p_resv_lower) else $error("lower high reserved bits set");
    a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse too long");
    a_sync_cause: assert property (p_sync_cause) else $error("sync pulse without edge");
endmodule : fdm_monitor_checker
bind fdm_monitor fdm_monitor_checker chk (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_chan_mask(reg_chan_mask), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sysref_in(sysref_in), .monitor_sync(monitor_sync), .overrange_out_a(overrange_out_a));

// ---- test/fdm_monitor_tb_top.sv ----
// Purpose: Register, detection and sync tests of the over-range monitor.
// Assumes: Inputs change on the falling edge only.
// Notes:   Channel B shares channel A's magnitude but keeps its own pin control.
`timescale 1ns/1ps
module fdm_monitor_tb_top;
    import fdm_pkg::*;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sysref_in, reg_rvalid, out_a, out_b;
    logic [ADDR_W-1:0] reg_addr = 12'h000;
    logic [DATA_W-1:0] reg_wdata = 8'h00, reg_rdata;
    logic [1:0] chan = 2'h0, monitor_sync;
    logic [MAG_W-1:0] mag_a = 13'h0000;
    logic [ADDR_W-1:0] addrs [9] = '{ADDR_PIN_CTRL, ADDR_UPPER_LO, ADDR_UPPER_HI, ADDR_LOWER_LO,
        ADDR_LOWER_HI, ADDR_DWELL_LO, ADDR_DWELL_HI, ADDR_SYNC_CTRL, 12'h246};
    logic [DATA_W-1:0] masks [9] = '{8'h0D, 8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'h03, 8'h00};
    logic [DATA_W-1:0] cfg [6] = '{8'h00, 8'h10, 8'h00, 8'h08, 8'h02, 8'h01};
    int error_cnt = 0, tests_run = 0, sync_cnt = 0, sync_cnt_b = 0, sync_base = 0;
    always #2.5 clk = ~clk;
    // Pulse counters per channel; only this process writes them
    always @(posedge clk) begin
        if (monitor_sync[0] === 1'b1) sync_cnt <= sync_cnt + 1;
        if (monitor_sync[1] === 1'b1) sync_cnt_b <= sync_cnt_b + 1;
    end
    fdm_host_model host (.clk(clk), .sysref_in(sysref_in));
    // Both channels see one magnitude, so channel B can be held against A
    fdm_monitor dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_chan_mask(chan), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .mag_a(mag_a),
        .mag_b(mag_a), .sysref_in(sysref_in), .monitor_sync(monitor_sync), .overrange_out_a(out_a),
        .overrange_out_b(out_b));
    task automatic cmp_reg(input string nm, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : cmp_reg
    task automatic cmp_pin(input string nm, input logic exp, input logic got);
        cmp_reg(nm, {7'h00, exp}, {7'h00, got});
    endtask : cmp_pin
    // One-cycle write strobe, returns on the falling edge after it
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] m);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        chan = m;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr
    // Read answer is fixed at one cycle, so no wait loop is needed
    task automatic rd(input logic [11:0] a, input logic [1:0] m, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        chan = m;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        cmp_pin("rvalid", 1'b1, reg_rvalid);
        cmp_reg("rdata", exp, reg_rdata);
    endtask : rd
    task automatic step(input logic [12:0] m, input logic e);
        mag_a = m;
        @(negedge clk);
        cmp_pin("pin_a", e, out_a);
    endtask : step
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 9; i++) rd(addrs[i], 2'h1, 8'h00);
        for (int i = 0; i < 9; i++) begin
            wr(addrs[i], 8'hFF, 2'h3);
            rd(addrs[i], 2'h2, masks[i]);
        end
        cmp_pin("pin_a", 1'b1, out_a);
        cmp_pin("pin_b", 1'b1, out_b);
        wr(ADDR_PIN_CTRL, 8'h08, 2'h3);
        @(negedge clk);
        cmp_pin("pin_a", 1'b0, out_a);
        $display("test registers done");
        for (int i = 0; i < 6; i++) wr(addrs[i + 1], cfg[i], 2'h3);
        wr(ADDR_PIN_CTRL, 8'h01, 2'h3);
        step(13'h1000, 1'b0);
        step(13'h1001, 1'b1);
        for (int i = 0; i < 200; i++) step(13'h07FF, 1'b1);
        step(13'h0800, 1'b1);
        for (int i = 0; i < 257; i++) step(13'h07FF, 1'b1);
        step(13'h07FF, 1'b0);
        step(13'h1001, 1'b1);
        wr(ADDR_PIN_CTRL, 8'h00, 2'h1);
        step(13'h1001, 1'b0);
        cmp_pin("pin_b", 1'b1, out_b);
        wr(ADDR_PIN_CTRL, 8'h01, 2'h1);
        step(13'h1001, 1'b1);
        $display("test detection done");
        wr(ADDR_SYNC_CTRL, 8'h01, 2'h1);
        sync_base = sync_cnt;
        host.send(2);
        cmp_reg("sync_count", 8'h02, 8'(sync_cnt - sync_base));
        wr(ADDR_SYNC_CTRL, 8'h03, 2'h1);
        sync_base = sync_cnt;
        host.send(2);
        cmp_reg("sync_count", 8'h01, 8'(sync_cnt - sync_base));
        rd(ADDR_SYNC_CTRL, 2'h1, 8'h02);
        wr(ADDR_SYNC_CTRL, 8'h02, 2'h1);
        sync_base = sync_cnt;
        host.send(1);
        cmp_reg("sync_count", 8'h00, 8'(sync_cnt - sync_base));
        // Channel B was armed for next-edge by the all-ones write: one pulse only
        cmp_reg("sync_count_b", 8'h01, sync_cnt_b[7:0]);
        rd(ADDR_SYNC_CTRL, 2'h2, 8'h02);
        $display("test sync done");
        report_and_stop();
    end
endmodule : fdm_monitor_tb_top
